// ===== hdl/rdsc_pkg.sv
// Summary of operation
// - Each card takes five bytes of relay bits shifted in serially.
// - A data bit is captured on each rising edge of the shift clock while chip select is low.
// - Once the chain is full each new bit pushes the oldest bit out.
// - A high strobe copies each selected slot's shift chain into its output latches.
// - On strobe the selected relays energize if outputs are enabled.
// - Driver outputs are active low; low energizes a relay.
// - While the output-disable line is high every driver is off.
// - A four-bit slot address routes data, clock and select to a slot.
// - Address all ones loads the strobe-select chain choosing slots.
package rdsc_pkg;
    localparam int BYTES_PER_CARD = 5;
    localparam int BITS_PER_BYTE = 8;
    localparam int SLOT_COUNT = 15;
    localparam int ADDR_W = 4;
    localparam logic [3:0] STROBE_SEL_ADDR = 4'hF;
    localparam logic OUT_OFF = 1'b1;
endpackage

// ===== hdl/rdsc_relay_chain.sv
`timescale 1ns/100ps
module rdsc_relay_chain #(
    parameter int BYTES = rdsc_pkg::BYTES_PER_CARD,
    parameter int SLOTS = rdsc_pkg::SLOT_COUNT
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic relay_data,
    input wire logic shift_clk,
    input wire logic chip_sel_b,
    input wire logic strobe,
    input wire logic relay_output_disable,
    input wire logic [rdsc_pkg::ADDR_W-1:0] slot_addr,
    output logic [SLOTS*BYTES*rdsc_pkg::BITS_PER_BYTE-1:0] relay_drive_b,
    output logic [SLOTS-1:0] chain_out,
    output logic [SLOTS-1:0] strobe_select_data
);

    // bits per byte, per card and across the backplane
    localparam int BPB = rdsc_pkg::BITS_PER_BYTE;
    localparam int NB = BYTES * BPB;
    localparam int AW = rdsc_pkg::ADDR_W;
    localparam int DW = SLOTS * NB;

    typedef struct packed {
        // last sampled level of the host shift clock
        logic clk_d;
        // serial chains, then the latches behind them
        logic [SLOTS-1:0][NB-1:0] shift;
        logic [SLOTS-1:0][NB-1:0] latch;
        // strobe-select chain and cascade bits
        logic [SLOTS-1:0] sel;
        logic [SLOTS-1:0] cout;
        // registered copy of the driver pins
        logic [DW-1:0] drive_b;
    } rdsc_state_t;

    // drivers leave reset switched off, never energized
    localparam rdsc_state_t ST_RESET = '{
        clk_d: 1'b0,
        shift: '0,
        latch: '0,
        sel: '0,
        cout: '0,
        drive_b: {DW{rdsc_pkg::OUT_OFF}}
    };

    rdsc_state_t st_reg;
    rdsc_state_t st_next;

    // host clock edge and address decode
    logic shift_rise;
    logic shift_take;
    logic addr_is_sel;
    logic addr_in_range;
    logic sel_take;

    // per-slot routing of data, clock, select and strobe
    logic [SLOTS-1:0] slot_match;
    logic [SLOTS-1:0] slot_data;
    logic [SLOTS-1:0] slot_clk_rise;
    logic [SLOTS-1:0] slot_cs_b;
    logic [SLOTS-1:0] slot_hit;
    logic [SLOTS-1:0] slot_strobe;

    // select chain
    logic [SLOTS-1:0] sel_in;
    logic [SLOTS-1:0] sel_upd;

    // card chains, byte by byte
    logic [SLOTS-1:0][BYTES-1:0] byte_in;
    logic [SLOTS-1:0][BYTES-1:0] byte_out;
    logic [SLOTS-1:0][NB-1:0] shift_upd;
    logic [SLOTS-1:0] cout_upd;

    // output side
    logic [SLOTS-1:0][NB-1:0] latch_upd;
    logic [SLOTS-1:0][NB-1:0] drive_upd;

    // shift_clk is sampled, so each level must last a core_clk cycle
    assign shift_rise = shift_clk & ~st_reg.clk_d;

    assign shift_take = shift_rise &
        ~chip_sel_b;

    assign addr_is_sel = (slot_addr == rdsc_pkg::STROBE_SEL_ADDR);

    // addresses past the last fitted slot shift no card chain
    assign addr_in_range = (32'(slot_addr) < SLOTS);

    assign sel_take = shift_take &
        addr_is_sel;

    generate
        for (genvar s = 0; s < SLOTS; s++) begin : g_decode
            // the address routes data, clock and select to one slot
            assign slot_match[s] = addr_in_range & ~addr_is_sel &
                (slot_addr == AW'(s));

            assign slot_data[s] = slot_match[s] &
                relay_data;

            assign slot_clk_rise[s] = slot_match[s] & shift_rise;

            assign slot_cs_b[s] = ~slot_match[s] |
                chip_sel_b;

            assign slot_hit[s] = slot_clk_rise[s] &
                ~slot_cs_b[s];

            // strobe is a level; only selected slots listen
            assign slot_strobe[s] = strobe & st_reg.sel[s];
        end
    endgenerate

    generate
        for (genvar s = 0; s < SLOTS; s++) begin : g_select
            // pattern enters at slot 0 and moves towards higher slots
            if (s == 0) begin : g_head
                assign sel_in[s] = relay_data;
            end else begin : g_link
                assign sel_in[s] = st_reg.sel[s-1];
            end

            assign sel_upd[s] = sel_take ?
                sel_in[s] :
                st_reg.sel[s];
        end
    endgenerate

    generate
        for (genvar s = 0; s < SLOTS; s++) begin : g_card
            for (genvar k = 0; k < BYTES; k++) begin : g_byte
                // each byte register feeds the next one up the chain
                if (k == 0) begin : g_first
                    assign byte_in[s][k] = slot_data[s];
                end else begin : g_next
                    assign byte_in[s][k] = byte_out[s][k-1];
                end

                assign byte_out[s][k] = st_reg.shift[s][k*BPB+BPB-1];

                for (genvar j = 0; j < BPB; j++) begin : g_bit
                    localparam int IDX = k * BPB + j;
                    logic bit_in;

                    if (j == 0) begin : g_low
                        assign bit_in = byte_in[s][k];
                    end else begin : g_up
                        assign bit_in = st_reg.shift[s][IDX-1];
                    end

                    assign shift_upd[s][IDX] = slot_hit[s] ?
                        bit_in :
                        st_reg.shift[s][IDX];
                end
            end
        end
    endgenerate

    generate
        for (genvar s = 0; s < SLOTS; s++) begin : g_cascade
            // oldest bit of the full chain leaves for the next card
            assign cout_upd[s] = slot_hit[s] ?
                byte_out[s][BYTES-1] :
                st_reg.cout[s];
        end
    endgenerate

    generate
        for (genvar s = 0; s < SLOTS; s++) begin : g_latch
            for (genvar b = 0; b < NB; b++) begin : g_bit
                // a held strobe keeps copying; late shifts show through
                assign latch_upd[s][b] = slot_strobe[s] ?
                    st_reg.shift[s][b] :
                    st_reg.latch[s][b];
            end
        end
    endgenerate

    generate
        for (genvar s = 0; s < SLOTS; s++) begin : g_drive
            for (genvar b = 0; b < NB; b++) begin : g_bit
                // disable wins even in the strobe cycle
                assign drive_upd[s][b] = relay_output_disable ?
                    rdsc_pkg::OUT_OFF :
                    ~latch_upd[s][b];
            end
        end
    endgenerate

    // one combined next-state copy, registered below
    always_comb begin
        st_next = st_reg;

        st_next.clk_d = shift_clk;

        st_next.shift = shift_upd;
        st_next.cout = cout_upd;

        st_next.sel = sel_upd;

        st_next.latch = latch_upd;
        st_next.drive_b = drive_upd;
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            // constants only; relays stay off until a strobe
            st_reg <= ST_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    // every output comes straight from the state flops
    assign relay_drive_b = st_reg.drive_b;
    assign chain_out = st_reg.cout;
    assign strobe_select_data = st_reg.sel;
endmodule

// ===== tb/rdsc_chain_asserts.sv
`timescale 1ns/100ps
module rdsc_chain_asserts #(
    parameter int BYTES = 5,
    parameter int SLOTS = 15
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic relay_data,
    input wire logic shift_clk,
    input wire logic chip_sel_b,
    input wire logic strobe,
    input wire logic relay_output_disable,
    input wire logic [3:0] slot_addr,
    input wire logic [SLOTS*BYTES*8-1:0] relay_drive_b,
    input wire logic [SLOTS-1:0] chain_out,
    input wire logic [SLOTS-1:0] strobe_select_data
);
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);
    sequence quiet_s;
        (!strobe && !relay_output_disable)[*3];
    endsequence
    sequence sel_take_s;
        $rose(shift_clk) && !chip_sel_b && slot_addr == 4'hF;
    endsequence
    sequence first_slot_take_s;
        $rose(shift_clk) && !chip_sel_b && slot_addr == 4'h0;
    endsequence
    drive_off_a: assert property (relay_output_disable |=>
        &relay_drive_b)
        else $error("drive on while disabled");
    latch_hold_a: assert property (quiet_s |=>
        $stable(relay_drive_b))
        else $error("drive moved without strobe");
    sel_shift_a: assert property (sel_take_s |=>
        strobe_select_data ==
        SLOTS'({$past(strobe_select_data), $past(relay_data)}))
        else $error("select chain did not shift");
    sel_hold_a: assert property (
        !($rose(shift_clk) && !chip_sel_b && slot_addr == 4'hF) |=>
        $stable(strobe_select_data))
        else $error("select chain moved without a shift");
    cascade_hold_a: assert property (
        !($rose(shift_clk) && !chip_sel_b) |=> $stable(chain_out))
        else $error("cascade bit moved without a shift");
    slot_route_a: assert property (first_slot_take_s |=>
        $stable(chain_out >> 1))
        else $error("shift reached a slot not addressed");
endmodule

// ===== tb/rdsc_host.sv
`timescale 1ns/100ps
module rdsc_host (
    input wire logic core_clk,
    output logic relay_data,
    output logic shift_clk,
    output logic chip_sel_b,
    output logic strobe,
    output logic relay_output_disable,
    output logic [3:0] slot_addr
);
    initial begin
        {relay_data, shift_clk, strobe, slot_addr} = '0;
        {chip_sel_b, relay_output_disable} = 2'b11;
    end
    // msb first; data held across the whole clock pulse
    task shift(input logic [3:0] a, input logic [39:0] d, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            @(posedge core_clk);
            {slot_addr, chip_sel_b, relay_data} <= {a, 1'b0, d[i]};
            @(posedge core_clk);
            shift_clk <= 1'b1;
            @(posedge core_clk);
            shift_clk <= 1'b0;
        end
        @(posedge core_clk);
        {chip_sel_b, relay_data} <= {1'b1, ~relay_data};
    endtask
    task pulse(input logic v);
        @(posedge core_clk);
        strobe <= v;
    endtask
    task en(input logic v);
        @(posedge core_clk);
        relay_output_disable <= v;
    endtask
endmodule

// ===== tb/tb_relay_driver_shift_chain.sv
`timescale 1ns/100ps
module tb_relay_driver_shift_chain;
    localparam logic [39:0] P = 40'hA50F3C817E;
    localparam logic [79:0] E = {40'hFFFFFFFFFF, ~P};
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic relay_data, shift_clk, chip_sel_b, strobe, relay_output_disable;
    logic [3:0] slot_addr;
    logic [79:0] relay_drive_b;
    logic [1:0] chain_out;
    logic [1:0] strobe_select_data;
    int error_cnt = 0;
    int check_count = 0;
    always #4 core_clk = ~core_clk;
    rdsc_host rdsc_host_i (.core_clk(core_clk), .relay_data(relay_data),
        .shift_clk(shift_clk), .chip_sel_b(chip_sel_b), .strobe(strobe),
        .relay_output_disable(relay_output_disable), .slot_addr(slot_addr));
    rdsc_relay_chain #(.SLOTS(2)) rdsc_relay_chain_i (.core_clk(core_clk),
        .rst_b(rst_b), .relay_data(relay_data), .shift_clk(shift_clk),
        .chip_sel_b(chip_sel_b), .strobe(strobe), .slot_addr(slot_addr),
        .relay_output_disable(relay_output_disable), .chain_out(chain_out),
        .relay_drive_b(relay_drive_b),
        .strobe_select_data(strobe_select_data));
    task chk(input logic [79:0] got, input logic [79:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task wrap_up;
        if (error_cnt == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge core_clk);
        rst_b <= 1'b1;
        @(negedge core_clk);
        chk(relay_drive_b, '1);
        rdsc_host_i.en(1'b0);
        rdsc_host_i.shift(4'h0, P, 40);
        rdsc_host_i.shift(4'hF, 40'h1, 2);
        @(negedge core_clk);
        chk({78'h0, strobe_select_data}, 80'h1);
        rdsc_host_i.pulse(1'b1);
        rdsc_host_i.pulse(1'b0);
        repeat (3) @(negedge core_clk);
        chk(relay_drive_b, E);
        rdsc_host_i.shift(4'h0, 40'h0, 1);
        @(negedge core_clk);
        chk({78'h0, chain_out}, 80'h1);
        chk(relay_drive_b, E);
        rdsc_host_i.en(1'b1);
        repeat (2) @(negedge core_clk);
        chk(relay_drive_b, '1);
        wrap_up();
    end
endmodule
bind rdsc_relay_chain rdsc_chain_asserts #(.BYTES(BYTES), .SLOTS(SLOTS))
    rdsc_chain_asserts_i (.core_clk(core_clk), .rst_b(rst_b), .strobe(strobe),
    .relay_data(relay_data), .shift_clk(shift_clk), .chip_sel_b(chip_sel_b),
    .slot_addr(slot_addr), .chain_out(chain_out),
    .strobe_select_data(strobe_select_data),
    .relay_output_disable(relay_output_disable), .relay_drive_b(relay_drive_b));
